// ### design/ssrw_map.svh
// Constants of the supply supervisor: timing figures and input bit slots.
// Assumes a 50 MHz core clock; counts are derived from the figures here.
`ifndef SSRW_MAP_SVH
`define SSRW_MAP_SVH

// Core clock rate in MHz (20 ns period)
`define SSRW_CLK_MHZ 50
// Time base tick period in ms
`define SSRW_TICK_MS 1
// Cycles per tick, derived from the tick period and the clock rate
`define SSRW_TICK_CYCLES (`SSRW_TICK_MS * 1000 * `SSRW_CLK_MHZ)
// Reset timeout in ms
`define SSRW_RST_TIMEOUT_MS 200
// Watchdog period in ms (1.6 s)
`define SSRW_WD_PERIOD_MS 1600
// Timeouts expressed in ticks
`define SSRW_RST_TICKS (`SSRW_RST_TIMEOUT_MS / `SSRW_TICK_MS)
`define SSRW_WD_TICKS (`SSRW_WD_PERIOD_MS / `SSRW_TICK_MS)

// Bit slots of the synchronised input vector
`define SSRW_IN_W 6
`define SSRW_IN_SUPPLY_LOW 0
`define SSRW_IN_LOW_LINE 1
`define SSRW_IN_MAIN_ABOVE_BACKUP 2
`define SSRW_IN_KICK 3
`define SSRW_IN_WD_DISABLE 4
`define SSRW_IN_CS_N 5

`endif

// ### design/ssrw_pkg.sv
// Types shared by the supply supervisor modules.
// Assumes nothing beyond a SystemVerilog compiler.
package ssrw_pkg;
	// Reset sequencer: running, or holding reset
	typedef enum logic {st_run, st_hold} ssrw_state_t;
endpackage

// ### design/ssrw_tick_if.sv
// Carrier of the time base tick between the divider and the sequencer.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface ssrw_tick_if;
	logic tick;
	modport src (output tick);
	modport snk (input tick);
endinterface

// ### design/ssrw_timebase.sv
// Free-running divider that gives a one-cycle tick every TICK_CYCLES.
// Assumes clk is the core clock and srst a synchronous reset.
`timescale 1ns/10ps
module ssrw_timebase #(
	parameter int TICK_CYCLES = 50000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Tick out
	ssrw_tick_if.src tb
);
	localparam int CW = $clog2(TICK_CYCLES);

	generate
		if (TICK_CYCLES < 2) begin : g_bad
			$error("TICK_CYCLES must be at least 2");
		end
	endgenerate

	logic [CW-1:0] div_r;
	logic [CW-1:0] div_nxt;
	logic tick_r;
	logic tick_nxt;

	// Wrap at the end of each period and flag it for one cycle
	always_comb begin
		tick_nxt = 1'b0;
		div_nxt = div_r + 1'b1;
		if (div_r == CW'(TICK_CYCLES - 1)) begin
			div_nxt = '0;
			tick_nxt = 1'b1;
		end
	end

	// Registers only
	always_ff @(posedge clk) begin
		if (srst) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tb.tick = tick_r;
endmodule

// ### design/ssrw_top.sv
// Digital core of a supply supervisor with reset timer and watchdog.
// Assumes comparator results and host pins arrive asynchronously.
`timescale 1ns/10ps
`include "ssrw_map.svh"
module ssrw_top #(
	parameter int TICK_CYCLES = `SSRW_TICK_CYCLES,
	parameter int RST_TICKS = `SSRW_RST_TICKS,
	parameter int WD_TICKS = `SSRW_WD_TICKS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Comparator results
	input wire logic supply_low_in,
	input wire logic low_line_in,
	input wire logic main_above_backup_in,
	// Host side pins
	input wire logic activity_kick_in,
	input wire logic watchdog_disable_in,
	input wire logic chip_select_n_in,
	// Outputs
	output logic reset_n_o,
	output logic reset_o,
	output logic power_fail_warning_n,
	output logic chip_select_n_o,
	output logic ram_from_main_o
);
	localparam int HW = $clog2(RST_TICKS + 1);
	localparam int WW = $clog2(WD_TICKS + 1);

	generate
		if (RST_TICKS < 1 || WD_TICKS < 1) begin : g_bad
			$error("RST_TICKS and WD_TICKS must be at least 1");
		end
	endgenerate

	ssrw_tick_if tick_if ();

	ssrw_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
		.clk(clk),
		.srst(srst),
		.tb(tick_if.src)
	);

	logic tick;
	assign tick = tick_if.tick;

	// Two-stage synchroniser for every pin, plus a kick history flop
	logic [`SSRW_IN_W-1:0] meta_r;
	logic [`SSRW_IN_W-1:0] sync_r;
	logic kick_d_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_r <= '0;
			sync_r <= '0;
			kick_d_r <= 1'b0;
		end else begin
			meta_r <= {chip_select_n_in, watchdog_disable_in,
				activity_kick_in, main_above_backup_in,
				low_line_in, supply_low_in};
			sync_r <= meta_r;
			kick_d_r <= sync_r[`SSRW_IN_KICK];
		end
	end

	logic supply_low_s;
	logic low_line_s;
	logic main_above_s;
	logic wd_dis_s;
	logic cs_n_s;
	logic kick_edge;
	assign supply_low_s = sync_r[`SSRW_IN_SUPPLY_LOW];
	assign low_line_s = sync_r[`SSRW_IN_LOW_LINE];
	assign main_above_s = sync_r[`SSRW_IN_MAIN_ABOVE_BACKUP];
	assign wd_dis_s = sync_r[`SSRW_IN_WD_DISABLE];
	assign cs_n_s = sync_r[`SSRW_IN_CS_N];
	assign kick_edge = sync_r[`SSRW_IN_KICK] ^ kick_d_r;

	// Sequencer and counters
	ssrw_pkg::ssrw_state_t st_r;
	ssrw_pkg::ssrw_state_t st_nxt;
	logic [HW-1:0] hold_cnt_r;
	logic [HW-1:0] hold_cnt_nxt;
	logic [WW-1:0] wd_cnt_r;
	logic [WW-1:0] wd_cnt_nxt;
	logic rst_act_nxt;
	logic wd_expire;

	// Watchdog runs only outside reset; disable keeps it parked at zero
	assign wd_expire = tick && !wd_dis_s &&
		(wd_cnt_r == WW'(WD_TICKS - 1));

	always_comb begin
		st_nxt = st_r;
		hold_cnt_nxt = hold_cnt_r;
		wd_cnt_nxt = wd_cnt_r;
		unique case (st_r)
			ssrw_pkg::st_hold: begin
				if (supply_low_s) begin
					hold_cnt_nxt = '0;
				end else if (tick) begin
					if (hold_cnt_r == HW'(RST_TICKS - 1)) begin
						st_nxt = ssrw_pkg::st_run;
						hold_cnt_nxt = '0;
					end else begin
						hold_cnt_nxt = hold_cnt_r + 1'b1;
					end
				end
			end
			ssrw_pkg::st_run: begin
				if (supply_low_s || wd_expire) begin
					st_nxt = ssrw_pkg::st_hold;
					hold_cnt_nxt = '0;
				end
			end
		endcase
		rst_act_nxt = (st_nxt == ssrw_pkg::st_hold);
		// Count only while reset is released and kicks are absent
		if (rst_act_nxt || st_r == ssrw_pkg::st_hold || wd_dis_s ||
			kick_edge) begin
			wd_cnt_nxt = '0;
		end else if (tick) begin
			wd_cnt_nxt = wd_cnt_r + 1'b1;
		end
	end

	// Registers only; srst starts a full power-up reset timeout
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= ssrw_pkg::st_hold;
			hold_cnt_r <= '0;
			wd_cnt_r <= '0;
		end else begin
			st_r <= st_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			wd_cnt_r <= wd_cnt_nxt;
		end
	end

	// Output flops; both reset polarities come from one next value
	logic reset_n_r;
	logic reset_r;
	logic pfw_n_r;
	logic cs_n_r;
	logic ram_main_r;
	logic reset_n_nxt;
	logic reset_nxt;
	logic pfw_n_nxt;
	logic cs_n_nxt;
	logic ram_main_nxt;

	always_comb begin
		reset_n_nxt = !rst_act_nxt;
		reset_nxt = rst_act_nxt;
		pfw_n_nxt = !low_line_s;
		// Gate passes only while reset is released
		cs_n_nxt = rst_act_nxt ? 1'b1 : cs_n_s;
		// Backup only when main is below both threshold and backup
		ram_main_nxt = !supply_low_s || main_above_s;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			reset_n_r <= 1'b0;
			reset_r <= 1'b1;
			pfw_n_r <= 1'b1;
			cs_n_r <= 1'b1;
			ram_main_r <= 1'b1;
		end else begin
			reset_n_r <= reset_n_nxt;
			reset_r <= reset_nxt;
			pfw_n_r <= pfw_n_nxt;
			cs_n_r <= cs_n_nxt;
			ram_main_r <= ram_main_nxt;
		end
	end

	assign reset_n_o = reset_n_r;
	assign reset_o = reset_r;
	assign power_fail_warning_n = pfw_n_r;
	assign chip_select_n_o = cs_n_r;
	assign ram_from_main_o = ram_main_r;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_low_holds;
		supply_low_s |=> !reset_n_o;
	endproperty
	a_low_holds: assert property (p_low_holds)
		else $error("reset released while supply low");

	property p_release_time;
		$rose(reset_n_o) |-> $past(tick) &&
			$past(hold_cnt_r) == HW'(RST_TICKS - 1);
	endproperty
	a_release_time: assert property (p_release_time)
		else $error("reset released before the timeout");

	property p_wd_fire;
		(st_r == ssrw_pkg::st_run) && !kick_edge && wd_expire
			|=> !reset_n_o ##1 (hold_cnt_r == '0);
	endproperty
	a_wd_fire: assert property (p_wd_fire)
		else $error("watchdog expiry did not assert reset");

	property p_inverse;
		reset_o == !reset_n_o;
	endproperty
	a_inverse: assert property (p_inverse)
		else $error("reset outputs not inverse");

	property p_warn;
		low_line_s |=> !power_fail_warning_n;
	endproperty
	a_warn: assert property (p_warn)
		else $error("power-fail warning not low");

	property p_gate_off;
		!reset_n_o |-> chip_select_n_o;
	endproperty
	a_gate_off: assert property (p_gate_off)
		else $error("chip select active during reset");

	property p_ram_sel;
		(!supply_low_s |=> ram_from_main_o) and
		(supply_low_s && !main_above_s |=> !ram_from_main_o);
	endproperty
	a_ram_sel: assert property (p_ram_sel)
		else $error("wrong RAM supply source");

	sequence s_kick_free;
		reset_n_o && kick_edge;
	endsequence
	property p_wd_clear;
		(s_kick_free |=> wd_cnt_r == '0) and
		(!reset_n_o |-> wd_cnt_r == '0);
	endproperty
	a_wd_clear: assert property (p_wd_clear)
		else $error("watchdog count not cleared");

	property p_restart;
		(st_r == ssrw_pkg::st_hold) && supply_low_s |=> hold_cnt_r == '0;
	endproperty
	a_restart: assert property (p_restart)
		else $error("timeout not restarted on supply dip");

	property p_pass;
		reset_n_o |-> chip_select_n_o == $past(cs_n_s);
	endproperty
	a_pass: assert property (p_pass)
		else $error("chip select not passed in normal running");

	property p_wd_off;
		wd_dis_s [*2] |-> wd_cnt_r == '0 && !wd_expire;
	endproperty
	a_wd_off: assert property (p_wd_off)
		else $error("watchdog counting while disabled");
endmodule

// ### sim/ssrw_host_model.sv
// Host processor model: toggles the watchdog kick pin at a chosen spacing.
// Assumes the core clock; a spacing of zero models a hung host.
`timescale 1ns/10ps
module ssrw_host_model (
	// Clock
	input wire logic clk,
	// Kick spacing in cycles, zero stops kicking
	input wire logic [7:0] gap,
	// Kick pin
	output logic kick
);
	// Start values at declaration so each variable has one process driving it
	logic kick_r = 1'b0;
	logic [7:0] cnt_r = 8'h00;

	// Toggle every gap+1 cycles; a stalled host simply stops toggling
	always @(posedge clk) begin
		if (gap == 8'h00) begin
			cnt_r <= 8'h00;
		end else if (cnt_r >= gap) begin
			cnt_r <= 8'h00;
			kick_r <= #1 ~kick_r;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	assign kick = kick_r;
endmodule

// ### sim/ssrw_top_tb_top.sv
// Self-checking bench for the supply supervisor core.
// Assumes small timing parameters so timeouts last tens of cycles.
`timescale 1ns/10ps
module ssrw_top_tb_top;
	localparam int TC = 4;
	localparam int RT = 5;
	localparam int WT = 8;
	// Release window after a cause clears, ticks may land anywhere
	localparam int RLO = (RT - 1) * TC;
	localparam int RHI = (RT + 1) * TC + 3;
	logic clk = 1'b0, srst = 1'b1, supply_low_in = 1'b0, low_line_in = 1'b0;
	logic main_above_backup_in = 1'b0, watchdog_disable_in = 1'b0;
	logic chip_select_n_in = 1'b0, activity_kick_in;
	logic reset_n_o, reset_o, power_fail_warning_n, chip_select_n_o;
	logic ram_from_main_o;
	logic [7:0] gap = 8'h0A;
	int n_fail = 0;
	int checks = 0;

	// 50 MHz core clock
	always #10 clk = ~clk;

	ssrw_top #(.TICK_CYCLES(TC), .RST_TICKS(RT), .WD_TICKS(WT)) ssrw_top_i (
		.clk(clk), .srst(srst), .supply_low_in(supply_low_in),
		.low_line_in(low_line_in),
		.main_above_backup_in(main_above_backup_in),
		.activity_kick_in(activity_kick_in),
		.watchdog_disable_in(watchdog_disable_in),
		.chip_select_n_in(chip_select_n_in), .reset_n_o(reset_n_o),
		.reset_o(reset_o), .power_fail_warning_n(power_fail_warning_n),
		.chip_select_n_o(chip_select_n_o), .ram_from_main_o(ram_from_main_o)
	);

	ssrw_host_model ssrw_host_model_i (
		.clk(clk), .gap(gap), .kick(activity_kick_in)
	);

	// Move to just after the nth rising edge from now, where inputs change
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %b want %b", $time, got, exp);
		end
	endtask

	// Bounded wait for the reset level; too early counts as badly as late
	task automatic wait_lvl(input logic exp, input int lo, input int hi);
		int n;
		n = 0;
		while (reset_n_o !== exp && n <= hi) begin
			step(1);
			n++;
		end
		chk(n >= lo && n <= hi, 1'b1);
		chk(reset_o, ~reset_n_o);
	endtask

	task automatic wrap_up();
		if (n_fail == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// A second dip inside the timeout must restart the count
	task automatic t_dip();
		supply_low_in = 1'b1;
		step(3);
		chk(reset_n_o, 1'b0);
		chk(reset_o, 1'b1);
		chk(chip_select_n_o, 1'b1);
		step(60);
		chk(reset_n_o, 1'b0);
		supply_low_in = 1'b0;
		step(10);
		supply_low_in = 1'b1;
		step(4);
		supply_low_in = 1'b0;
		wait_lvl(1'b1, RLO, RHI);
		step(4);
		chk(chip_select_n_o, 1'b0);
	endtask

	task automatic t_cs();
		for (int i = 1; i < 5; i++) begin
			chip_select_n_in = i[0];
			step(3);
			chk(chip_select_n_o, i[0]);
		end
	endtask

	task automatic t_power_fail_warning_n();
		low_line_in = 1'b1;
		step(3);
		chk(power_fail_warning_n, 1'b0);
		low_line_in = 1'b0;
		step(3);
		chk(power_fail_warning_n, 1'b1);
	endtask

	// All four comparator combinations for the RAM supply switch
	task automatic t_ram();
		for (int i = 0; i < 4; i++) begin
			supply_low_in = i[1];
			main_above_backup_in = i[0];
			step(3);
			chk(ram_from_main_o, !i[1] || i[0]);
		end
		supply_low_in = 1'b0;
		wait_lvl(1'b1, RLO, RHI);
	endtask

	// Hung host fires reset; count restarts from zero after the release
	task automatic t_wdog();
		step(100);
		chk(reset_n_o, 1'b1);
		gap = 8'h00;
		wait_lvl(1'b0, (WT - 1) * TC - 12, WT * TC + 4);
		wait_lvl(1'b1, RLO, RHI);
		wait_lvl(1'b0, (WT - 2) * TC, WT * TC + 4);
		wait_lvl(1'b1, RLO, RHI);
		watchdog_disable_in = 1'b1;
		// A single late sample could land between two watchdog resets;
		// sampling every 10 cycles always catches the 20-cycle pulse
		for (int i = 0; i < 8; i++) begin
			step(10);
			chk(reset_n_o, 1'b1);
		end
		watchdog_disable_in = 1'b0;
		gap = 8'h0A;
		step(20);
	endtask

	initial begin
		step(6);
		srst = 1'b0;
		wait_lvl(1'b1, RLO, RHI);
		t_dip();
		t_cs();
		t_power_fail_warning_n();
		t_ram();
		t_wdog();
		wrap_up();
	end

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		n_fail++;
		wrap_up();
	end
endmodule
